//--- hdl/tpu_regs.svh
`ifndef TPU_REGS_SVH
`define TPU_REGS_SVH

// ============================================================
// Register byte addresses on the Avalon-MM slave.
`define TPU_ADDR_MODE 8'h00
`define TPU_ADDR_COUNT 8'h04
`define TPU_ADDR_RELOAD 8'h08
`define TPU_ADDR_DUTY 8'h0c
`define TPU_ADDR_CHAN 8'h10
`define TPU_ADDR_EXT 8'h14
`define TPU_ADDR_STATUS 8'h18
`define TPU_ADDR_MASK 8'h1c
`define TPU_ADDR_CFG 8'h20

// ============================================================
// Field positions.
`define TPU_MODE_ENABLE 7
`define TPU_MODE_RATE_HI 6
`define TPU_MODE_RATE_LO 4
`define TPU_MODE_PULSE 1
`define TPU_MODE_PWM_OUTPUT_ENABLE 0
`define TPU_FIELD_HI 5
`define TPU_FIELD_LO 4
`define TPU_CFG_SLOW 0
`define TPU_CFG_EVENT 1
`define TPU_STATUS_OVF 0

// ============================================================
// Reset values and constants.
`define TPU_RST_BYTE 8'h00
`define TPU_RST_WORD 32'h0000_0000
`define TPU_MODE_MASK 8'hf3
`define TPU_FULL_SCALE 8'hff
`define TPU_PRE_MASK 7'h7f
`define TPU_RST_PRE 7'h00

`endif

//--- hdl/tpu_pkg.sv
// ============================================================
// Shared types of the timer and PWM unit.
package tpu_pkg;

	// Four-phase position of the extended PWM, Gray coded.
	typedef enum logic [1:0] {
		TPU_PH0 = 2'b00,
		TPU_PH1 = 2'b01,
		TPU_PH2 = 2'b11,
		TPU_PH3 = 2'b10
	} tpu_phase_t;

	// Prescale selection: 0 divides by 128, 7 divides by 1.
	typedef logic [2:0] tpu_rate_t;

endpackage : tpu_pkg

//--- hdl/tpu_tick_if.sv
`timescale 1ns/1ps
// ============================================================
// Link between the control core and the tick generator.
interface tpu_tick_if;
	import tpu_pkg::*;
	logic run; // Timer enabled; low also clears the prescaler.
	tpu_rate_t rate; // Prescale selection.
	logic slow_sel; // Count slow-oscillator ticks instead of the system clock.
	logic event_sel; // Count external pin edges.
	logic tick; // One-cycle count enable.
	modport ctrl (output run, output rate, output slow_sel, output event_sel, input tick);
	modport gen (input run, input rate, input slow_sel, input event_sel, output tick);
endinterface : tpu_tick_if

//--- hdl/tpu_tick_gen.sv
`timescale 1ns/1ps
`include "tpu_regs.svh"
// ============================================================
// Tick generator: prescaler and source selection.
module tpu_tick_gen (
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	input wire logic i_slow_tick,
	input wire logic i_event_pin,
	tpu_tick_if.gen tk
);
	import tpu_pkg::*;

	logic [6:0] pre_q; // Prescale count.
	logic [6:0] pre_d;
	logic ev_q; // Last sampled event pin level.
	logic tick_q; // Registered tick.
	logic tick_d;
	logic base; // One base-clock step.
	logic [6:0] mask; // Prescaler terminal mask.

	// Pick the base step and decide when the prescaler wraps.
	always_comb begin
		mask = `TPU_PRE_MASK >> tk.rate;
		base = tk.slow_sel ? i_slow_tick : 1'b1;
		pre_d = pre_q;
		tick_d = 1'b0;
		if (!tk.run) begin
			// A stopped timer restarts its prescaler from zero.
			pre_d = `TPU_RST_PRE;
		end else if (tk.event_sel) begin
			// Each rising pin edge is one count, bypassing the divider.
			tick_d = i_event_pin && !ev_q;
		end else if (base) begin
			pre_d = pre_q + 7'h01;
			tick_d = ((pre_q & mask) == mask);
		end
	end

	// Register the prescaler state.
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			pre_q <= `TPU_RST_PRE;
			ev_q <= 1'b0;
			tick_q <= 1'b0;
		end else begin
			pre_q <= pre_d;
			ev_q <= i_event_pin;
			tick_q <= tick_d;
		end
	end

	assign tk.tick = tick_q;

endmodule : tpu_tick_gen

//--- hdl/tpu_timer.sv
`timescale 1ns/1ps
`include "tpu_regs.svh"
// Summary of operation
// R1 - Eight-bit counter steps up each tick.
// R2 - Overflow sets flag; enabled flag raises interrupt.
// R3 - Event mode counts external pin pulses.
// R4 - Period from rate and reload, duty register.
// R5 - Pulse select picks continuous or one-pulse.
// R6 - One-pulse mode emits a single cycle.
// R7 - One-pulse end: flag set, output enable cleared.
// R8 - No extension compensation in one-pulse mode.
// R9 - Two channels, each gated by own bit.
// R10 - Cleared channel returns pin to GPIO state.
// R11 - Extension field picks four-phase compensation.
// R12 - Counter always reloads on overflow; here a count write in the same cycle wins instead.
// R13 - Green mode keeps running, never wakes system.
// R14 - Overflow at 0xff to 0x00; flag sticky.
// R15 - Output goes low when count equals duty.
// R16 - Reload writes take effect at next overflow.
// R17 - Software sets count equal reload before enabling.
// R18 - Continuous PWM starts high after each reload.
// R19 - Extension change applies after four-phase cycle.
module tpu_timer (
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic i_slow_tick,
	input wire logic i_event_pin,
	input wire logic [1:0] i_gpio_out,
	input wire logic [1:0] i_gpio_oe_n,
	output logic [1:0] o_pin_out,
	output logic [1:0] o_pin_oe_n,
	output logic o_irq
);
	import tpu_pkg::*;

	// ============================================================
	// State.
	logic [7:0] timer_mode_register_q, timer_mode_register_d; // Enable, rate, pulse, output.
	logic [7:0] count_register_q, count_register_d; // Live count.
	logic [7:0] reload_register_q, reload_register_d; // Reload buffer, used at overflow.
	logic [7:0] duty_register_q, duty_register_d; // Compare value ending the high part.
	logic [1:0] channel_enable_field_q, channel_enable_field_d; // Per-pin PWM gate.
	logic [1:0] extension_select_field_q, extension_select_field_d; // Written value.
	logic [1:0] ext_act_q, ext_act_d; // Extension value of the running cycle.
	tpu_phase_t phase_q, phase_d; // Four-phase position.
	logic [2:0] cfg_q, cfg_d; // Slow select, event select.
	logic status_q, status_d; // Overflow request flag.
	logic mask_q, mask_d; // Overflow interrupt enable.
	logic pwm_q, pwm_d; // Internal PWM level.
	logic live_q, live_d; // PWM was running last cycle.
	logic irq_q, irq_d;
	logic wait_q, wait_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] pin_out_q, pin_out_d, pin_oe_n_q, pin_oe_n_d;

	// ============================================================
	// Decode helpers.
	logic run, pulse_mode, pwm_output_enable, ovf, acc, wr, comp;
	logic [7:0] duty_end;
	tpu_tick_if tk ();

	assign run = timer_mode_register_q[`TPU_MODE_ENABLE];
	assign pulse_mode = timer_mode_register_q[`TPU_MODE_PULSE];
	assign pwm_output_enable = timer_mode_register_q[`TPU_MODE_PWM_OUTPUT_ENABLE];
	assign tk.run = run;
	assign tk.rate = timer_mode_register_q[`TPU_MODE_RATE_HI:`TPU_MODE_RATE_LO];
	assign tk.slow_sel = cfg_q[`TPU_CFG_SLOW];
	assign tk.event_sel = cfg_q[`TPU_CFG_EVENT]; // see R3
	// Overflow only from full scale, followed by the reload unless a count write lands in the same cycle.
	assign ovf = run && tk.tick && (count_register_q == `TPU_FULL_SCALE); // see R14
	// The register access completes in the cycle in which waitrequest is low.
	assign acc = (i_avs_read || i_avs_write) && !wait_q;
	assign wr = acc && i_avs_write && i_avs_byteenable[0];

	// One extra high count in selected phases; never in one-pulse mode.
	always_comb begin
		comp = 1'b0;
		case (ext_act_q)
			2'b01: comp = (phase_q == TPU_PH1); // see R11
			2'b10: comp = (phase_q == TPU_PH1) || (phase_q == TPU_PH3);
			2'b11: comp = (phase_q != TPU_PH0);
			default: comp = 1'b0;
		endcase
		if (pulse_mode) begin
			comp = 1'b0; // see R8
		end
		duty_end = comp ? duty_register_q + 8'h01 : duty_register_q;
	end

	tpu_tick_gen u_tick (
		.i_clk_sys(i_clk_sys),
		.i_resetn(i_resetn),
		.i_slow_tick(i_slow_tick),
		.i_event_pin(i_event_pin),
		.tk(tk)
	);

	// ============================================================
	// Next-state logic for the registers, counter and PWM.
	// The count keeps running in any power mode; there is no wake path at all.
	always_comb begin
		timer_mode_register_d = timer_mode_register_q;
		count_register_d = count_register_q;
		reload_register_d = reload_register_q;
		duty_register_d = duty_register_q;
		channel_enable_field_d = channel_enable_field_q;
		extension_select_field_d = extension_select_field_q;
		ext_act_d = ext_act_q;
		phase_d = phase_q;
		cfg_d = cfg_q;
		status_d = status_q;
		mask_d = mask_q;
		pwm_d = pwm_q;
		live_d = run && pwm_output_enable;
		// Counting.
		if (run && tk.tick) begin // see R13
			if (ovf) begin
				// Reload unless a count write lands in the same cycle; a pending reload write lands here.
				count_register_d = reload_register_q; // see R12, R16
			end else begin
				count_register_d = count_register_q + 8'h01; // see R1
			end
		end
		// Four-phase sequencing; disabling the timer resets it.
		if (!run) begin
			phase_d = TPU_PH0;
			ext_act_d = extension_select_field_q;
		end else if (ovf) begin
			case (phase_q)
				TPU_PH0: phase_d = TPU_PH1;
				TPU_PH1: phase_d = TPU_PH2;
				TPU_PH2: phase_d = TPU_PH3;
				default: begin
					phase_d = TPU_PH0;
					ext_act_d = extension_select_field_q; // see R19
				end
			endcase
		end
		// PWM level: high at the start, low at the duty match.
		if (!run || !pwm_output_enable) begin
			pwm_d = 1'b0;
		end else if (!live_q) begin
			pwm_d = 1'b1;
		end else if (ovf) begin
			pwm_d = !pulse_mode; // see R18, R5, R6
		end else if (tk.tick && (count_register_d == duty_end)) begin
			pwm_d = 1'b0; // see R15, R4
		end
		// A finished single pulse withdraws the output enable itself.
		if (ovf && pulse_mode) begin
			timer_mode_register_d[`TPU_MODE_PWM_OUTPUT_ENABLE] = 1'b0; // see R7
		end
		// Software writes; a write to the mode register wins over the auto clear.
		if (wr) begin
			if (i_avs_address == `TPU_ADDR_MODE) begin
				timer_mode_register_d = i_avs_writedata[7:0] & `TPU_MODE_MASK;
			end else if (i_avs_address == `TPU_ADDR_COUNT) begin
				count_register_d = i_avs_writedata[7:0];
			end else if (i_avs_address == `TPU_ADDR_RELOAD) begin
				reload_register_d = i_avs_writedata[7:0];
			end else if (i_avs_address == `TPU_ADDR_DUTY) begin
				duty_register_d = i_avs_writedata[7:0];
			end else if (i_avs_address == `TPU_ADDR_CHAN) begin
				channel_enable_field_d = i_avs_writedata[`TPU_FIELD_HI:`TPU_FIELD_LO];
			end else if (i_avs_address == `TPU_ADDR_EXT) begin
				extension_select_field_d = i_avs_writedata[`TPU_FIELD_HI:`TPU_FIELD_LO];
			end else if (i_avs_address == `TPU_ADDR_STATUS) begin
				if (i_avs_writedata[`TPU_STATUS_OVF]) begin
					status_d = 1'b0;
				end
			end else if (i_avs_address == `TPU_ADDR_MASK) begin
				mask_d = i_avs_writedata[`TPU_STATUS_OVF];
			end else if (i_avs_address == `TPU_ADDR_CFG) begin
				cfg_d = i_avs_writedata[2:0];
			end
		end
		// Overflow sets the flag after any clear, so a coincident event is kept.
		if (ovf) begin
			status_d = 1'b1; // see R2
		end
		irq_d = status_q && mask_q; // see R2
	end

	// ============================================================
	// Avalon slave: one wait state, then the access completes.
	always_comb begin
		wait_d = !((i_avs_read || i_avs_write) && wait_q);
		rdata_d = rdata_q;
		if (wait_q) begin
			rdata_d = `TPU_RST_WORD;
			if (i_avs_address == `TPU_ADDR_MODE) begin
				rdata_d[7:0] = timer_mode_register_q;
			end else if (i_avs_address == `TPU_ADDR_COUNT) begin
				rdata_d[7:0] = count_register_q;
			end else if (i_avs_address == `TPU_ADDR_DUTY) begin
				rdata_d[7:0] = duty_register_q;
			end else if (i_avs_address == `TPU_ADDR_CHAN) begin
				rdata_d[`TPU_FIELD_HI:`TPU_FIELD_LO] = channel_enable_field_q;
			end else if (i_avs_address == `TPU_ADDR_EXT) begin
				rdata_d[`TPU_FIELD_HI:`TPU_FIELD_LO] = extension_select_field_q;
			end else if (i_avs_address == `TPU_ADDR_STATUS) begin
				rdata_d[`TPU_STATUS_OVF] = status_q;
			end else if (i_avs_address == `TPU_ADDR_MASK) begin
				rdata_d[`TPU_STATUS_OVF] = mask_q;
			end else if (i_avs_address == `TPU_ADDR_CFG) begin
				rdata_d[2:0] = cfg_q;
			end
		end
	end

	// ============================================================
	// Pin multiplexer: PWM only while the channel is on, else GPIO.
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_pin
			always_comb begin
				if (run && pwm_output_enable && channel_enable_field_q[g]) begin // see R9
					pin_out_d[g] = pwm_q;
					pin_oe_n_d[g] = 1'b0;
				end else begin
					// The GPIO port value is kept live, so its last state returns.
					pin_out_d[g] = i_gpio_out[g]; // see R10
					pin_oe_n_d[g] = i_gpio_oe_n[g];
				end
			end
			always_ff @(posedge i_clk_sys or negedge i_resetn) begin
				if (!i_resetn) begin
					pin_out_q[g] <= 1'b0;
					pin_oe_n_q[g] <= 1'b1;
				end else begin
					pin_out_q[g] <= pin_out_d[g];
					pin_oe_n_q[g] <= pin_oe_n_d[g];
				end
			end
		end
	endgenerate

	// ============================================================
	// Register all core state.
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			timer_mode_register_q <= `TPU_RST_BYTE;
			count_register_q <= `TPU_RST_BYTE;
			reload_register_q <= `TPU_RST_BYTE;
			duty_register_q <= `TPU_RST_BYTE;
			channel_enable_field_q <= 2'b00;
			extension_select_field_q <= 2'b00;
			ext_act_q <= 2'b00;
			phase_q <= TPU_PH0;
			cfg_q <= 3'b000;
			status_q <= 1'b0;
			mask_q <= 1'b0;
			pwm_q <= 1'b0;
			live_q <= 1'b0;
			irq_q <= 1'b0;
			wait_q <= 1'b1;
			rdata_q <= `TPU_RST_WORD;
		end else begin
			timer_mode_register_q <= timer_mode_register_d;
			count_register_q <= count_register_d;
			reload_register_q <= reload_register_d;
			duty_register_q <= duty_register_d;
			channel_enable_field_q <= channel_enable_field_d;
			extension_select_field_q <= extension_select_field_d;
			ext_act_q <= ext_act_d;
			phase_q <= phase_d;
			cfg_q <= cfg_d;
			status_q <= status_d;
			mask_q <= mask_d;
			pwm_q <= pwm_d;
			live_q <= live_d;
			irq_q <= irq_d;
			wait_q <= wait_d;
			rdata_q <= rdata_d;
		end
	end

	assign o_avs_readdata = rdata_q;
	assign o_avs_waitrequest = wait_q;
	assign o_pin_out = pin_out_q;
	assign o_pin_oe_n = pin_oe_n_q;
	assign o_irq = irq_q;

	// ============================================================
	// Checks.
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_resetn);

	logic wr_count, wr_mode;
	assign wr_count = wr && (i_avs_address == `TPU_ADDR_COUNT);
	assign wr_mode = wr && (i_avs_address == `TPU_ADDR_MODE);

	property p_count_step;
		(run && tk.tick && !ovf && !wr_count) |=> (count_register_q == $past(count_register_q) + 8'h01);
	endproperty
	a_count_step: assert property (p_count_step) else $error("count did not step"); // see R1

	property p_reload;
		(ovf && !wr_count) |=> (count_register_q == $past(reload_register_q));
	endproperty
	a_reload: assert property (p_reload) else $error("no reload on overflow"); // see R12

	sequence s_flag_up;
		status_q ##1 (irq_q || !mask_q);
	endsequence
	property p_flag_irq;
		ovf |=> s_flag_up;
	endproperty
	a_flag_irq: assert property (p_flag_irq) else $error("overflow flag or irq missing"); // see R2

	property p_flag_sticky;
		(status_q && !(wr && (i_avs_address == `TPU_ADDR_STATUS))) |=> status_q;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped"); // see R14

	property p_duty_low;
		(live_q && run && pwm_output_enable && !ovf && tk.tick && !comp && !wr_count
			&& !wr_mode && (count_register_q + 8'h01 == duty_register_q)) |=> !pwm_q;
	endproperty
	a_duty_low: assert property (p_duty_low) else $error("pwm high past duty"); // see R15

	property p_one_shot;
		(ovf && pulse_mode && !wr_mode) |=> (!pwm_output_enable ##1 !pwm_q);
	endproperty
	a_one_shot: assert property (p_one_shot) else $error("one pulse did not end"); // see R7

	property p_no_comp;
		pulse_mode |-> !comp;
	endproperty
	a_no_comp: assert property (p_no_comp) else $error("compensation in pulse mode"); // see R8

	property p_ext_hold;
		(run && $past(run) && (ext_act_q != $past(ext_act_q))) |-> (phase_q == TPU_PH0);
	endproperty
	a_ext_hold: assert property (p_ext_hold) else $error("extension changed mid cycle"); // see R19

	property p_gpio;
		!channel_enable_field_q[0] |=> (o_pin_out[0] == $past(i_gpio_out[0])
			&& o_pin_oe_n[0] == $past(i_gpio_oe_n[0]));
	endproperty
	a_gpio: assert property (p_gpio) else $error("pin not back to gpio"); // see R10

	property p_bus;
		((i_avs_read || i_avs_write) && wait_q) |=> (!wait_q ##1 wait_q);
	endproperty
	a_bus: assert property (p_bus) else $error("bad waitrequest timing");

endmodule : tpu_timer

//--- test/tpu_tb.sv
`timescale 1ns/1ps
`include "tpu_regs.svh"
// ============================================================
// Self-checking bench of the timer and PWM unit.
module testbench;
	import tpu_pkg::*;
	typedef struct {
		string nm;
		logic [31:0] v;
	} tpu_note_t;
	logic clk = 1'b0; // System clock, 20 MHz.
	logic rst_n; // Reset, active low.
	logic [7:0] addr; // Bus address.
	logic rd; // Read request.
	logic wr_en; // Write request.
	logic [31:0] wdata; // Write data.
	logic [3:0] be; // Byte enables.
	logic [31:0] rdata; // Read data.
	logic wait_req; // Wait request.
	logic slow; // Slow-oscillator tick.
	logic evt; // Event count input.
	logic [1:0] gpio_out; // GPIO values.
	logic [1:0] gpio_oe_n; // GPIO enables, active low.
	logic [1:0] pin_out; // Pin values.
	logic [1:0] pin_oe_n; // Pin enables, active low.
	logic irq; // Interrupt line.
	int n_fail = 0; // Mismatches.
	int samples_checked = 0; // Comparisons.
	int cyc = 0; // Cycles run, for the hang guard.
	int ph; // Expected extension phase.
	int ext_on; // Extension mode in force.
	int ext_new; // Extension mode last written.
	logic [7:0] cnt_e; // Expected count.
	logic [31:0] seed = 32'h54ac4cc1; // Xorshift state.
	tpu_note_t notes[$]; // Expected read answers, oldest first.
	tpu_note_t nt; // Note under comparison.

	always #25 clk = ~clk;

	tpu_timer u_dut (
		.i_clk_sys(clk),
		.i_resetn(rst_n),
		.i_avs_address(addr),
		.i_avs_read(rd),
		.i_avs_write(wr_en),
		.i_avs_writedata(wdata),
		.i_avs_byteenable(be),
		.o_avs_readdata(rdata),
		.o_avs_waitrequest(wait_req),
		.i_slow_tick(slow),
		.i_event_pin(evt),
		.i_gpio_out(gpio_out),
		.i_gpio_oe_n(gpio_oe_n),
		.o_pin_out(pin_out),
		.o_pin_oe_n(pin_oe_n),
		.o_irq(irq)
	);

	// ============================================================
	// Checking and closing.
	task automatic stop_test;
		if (n_fail == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// Read answers are taken at the rising edge at which wait request is sampled low.
	always @(posedge clk) begin
		if (rd && wait_req === 1'b0) begin
			nt = notes.pop_front();
			chk(nt.nm, nt.v, rdata);
		end
	end

	// A hang is cut short here; the ceiling is far above the planned run.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_fail++;
			stop_test();
		end
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	// ============================================================
	// Drivers.
	// One bus access; the request is held until wait request is sampled low at a rising edge.
	// Only the hang guard ends a wait that never finishes.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= w;
		rd <= !w;
		@(posedge clk);
		while (wait_req !== 1'b0) begin
			n++;
			@(posedge clk);
		end
		// The slave inserts exactly one wait state per access.
		chk("wait states", 32'h1, 32'(n));
		rd <= 1'b0;
		wr_en <= 1'b0;
		be <= 4'hf;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] v, input string nm);
		notes.push_back(tpu_note_t'{nm, v});
		bus(1'b0, a, 32'h0);
	endtask : rdc

	// Each slow tick is one count at divide-by-one, so the bench paces the timer.
	task automatic tk(input int n);
		repeat (n) begin
			@(posedge clk);
			slow <= 1'b1;
			@(posedge clk);
			slow <= 1'b0;
			repeat (4) @(posedge clk);
		end
	endtask : tk

	task automatic rnd_gpio;
		seed = xs(seed);
		gpio_out <= seed[1:0];
		gpio_oe_n <= seed[3:2];
	endtask : rnd_gpio

	task automatic irqc(input logic e);
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk("irq", {31'h0, e}, {31'h0, irq});
	endtask : irqc

	// Channels that are on show the PWM level; the others mirror GPIO.
	task automatic pins(input logic [1:0] on, input logic lvl);
		logic [1:0] eo;
		repeat (3) @(posedge clk);
		@(negedge clk);
		eo = (on & {2{lvl}}) | (~on & gpio_out);
		chk("pin level", {30'h0, eo}, {30'h0, pin_out});
		chk("pin enable", {30'h0, ~on & gpio_oe_n}, {30'h0, pin_oe_n});
	endtask : pins

	// Count equal in count and reload before the enable is set.
	task automatic setup(input logic [7:0] c, input logic [7:0] d, input logic [7:0] m);
		wr(`TPU_ADDR_MODE, 32'h0);
		wr(`TPU_ADDR_COUNT, {24'h0, c});
		wr(`TPU_ADDR_RELOAD, {24'h0, c});
		wr(`TPU_ADDR_DUTY, {24'h0, d});
		wr(`TPU_ADDR_MODE, {24'h0, m});
		cnt_e = c;
		ph = 0;
	endtask : setup

	// Ticks through a period of f8..ff with duty fc, tracking phase and extension.
	task automatic run(input int n, input logic [1:0] on);
		logic cmp;
		repeat (n) begin
			tk(1);
			cnt_e = cnt_e + 8'h1;
			if (cnt_e == 8'h00) begin
				cnt_e = 8'hf8;
				ph = (ph + 1) % 4;
				if (ph == 0) ext_on = ext_new;
			end
			cmp = (ext_on == 1 && ph == 1) || (ext_on == 2 && ph % 2 == 1)
				|| (ext_on == 3 && ph != 0);
			pins(on, cnt_e < 8'hfc + {7'h0, cmp});
		end
	endtask : run

	// ============================================================
	// Scenarios.
	initial begin
		rst_n = 1'b0;
		addr = 8'h00;
		rd = 1'b0;
		wr_en = 1'b0;
		wdata = 32'h0;
		be = 4'hf;
		slow = 1'b0;
		evt = 1'b0;
		gpio_out = 2'b00;
		gpio_oe_n = 2'b11;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		// Clear after reset; the hole and the write-only reload read zero.
		for (int i = 0; i < 10; i++) begin
			rdc(8'(i * 4), 32'h0, "reset value");
		end
		wr(8'h30, 32'hff);
		rdc(8'h30, 32'h0, "hole");
		wr(`TPU_ADDR_MODE, 32'hffff_ff7f);
		rdc(`TPU_ADDR_MODE, 32'h73, "mode bits");
		be <= 4'he;
		wr(`TPU_ADDR_DUTY, 32'h5a);
		rdc(`TPU_ADDR_DUTY, 32'h0, "masked write");
		wr(`TPU_ADDR_DUTY, 32'hffff_ff5a);
		rdc(`TPU_ADDR_DUTY, 32'h5a, "duty");
		// Every prescale step: one count per 128 >> rate slow ticks.
		wr(`TPU_ADDR_CFG, 32'h1);
		for (int r = 0; r < 8; r++) begin
			setup(8'h40, 8'h00, 8'(8'h80 | (r << 4)));
			tk((128 >> r) - 1);
			rdc(`TPU_ADDR_COUNT, 32'h40, "count early");
			tk(1);
			rdc(`TPU_ADDR_COUNT, 32'h41, "count step");
		end
		// Overflow with a buffered reload, then the mask.
		setup(8'hfe, 8'h00, 8'hf0);
		wr(`TPU_ADDR_MASK, 32'h1);
		wr(`TPU_ADDR_RELOAD, 32'h0);
		tk(1);
		rdc(`TPU_ADDR_COUNT, 32'hff, "count");
		rdc(`TPU_ADDR_STATUS, 32'h0, "flag");
		tk(1);
		rdc(`TPU_ADDR_COUNT, 32'h00, "reload");
		rdc(`TPU_ADDR_STATUS, 32'h1, "flag");
		irqc(1'b1);
		tk(1);
		rdc(`TPU_ADDR_STATUS, 32'h1, "sticky flag");
		wr(`TPU_ADDR_STATUS, 32'h1);
		rdc(`TPU_ADDR_STATUS, 32'h0, "flag clear");
		irqc(1'b0);
		setup(8'hff, 8'h00, 8'hf0);
		wr(`TPU_ADDR_MASK, 32'h0);
		tk(1);
		rdc(`TPU_ADDR_COUNT, 32'hff, "reload");
		irqc(1'b0);
		wr(`TPU_ADDR_MASK, 32'h1);
		irqc(1'b1);
		wr(`TPU_ADDR_STATUS, 32'h1);
		irqc(1'b0);
		// Continuous PWM on both channels, then one at a time, then off.
		ext_on = 0;
		ext_new = 0;
		rnd_gpio();
		wr(`TPU_ADDR_CHAN, 32'h30);
		setup(8'hf8, 8'hfc, 8'h70);
		pins(2'b00, 1'b0);
		wr(`TPU_ADDR_MODE, 32'hf1);
		pins(2'b11, 1'b1);
		run(16, 2'b11);
		rnd_gpio();
		wr(`TPU_ADDR_CHAN, 32'h10);
		run(8, 2'b01);
		wr(`TPU_ADDR_CHAN, 32'h20);
		run(8, 2'b10);
		wr(`TPU_ADDR_CHAN, 32'h30);
		wr(`TPU_ADDR_MODE, 32'hf0);
		run(4, 2'b00);
		// One pulse per arming, with the extension field set but ignored.
		wr(`TPU_ADDR_EXT, 32'h30);
		wr(`TPU_ADDR_STATUS, 32'h1);
		setup(8'hf8, 8'hfc, 8'hf3);
		for (int p = 0; p < 2; p++) begin
			pins(2'b11, 1'b1);
			run(7, 2'b11);
			run(1, 2'b00);
			rdc(`TPU_ADDR_MODE, 32'hf2, "auto clear");
			rdc(`TPU_ADDR_STATUS, 32'h1, "flag");
			run(8, 2'b00);
			wr(`TPU_ADDR_MODE, 32'hf3);
		end
		// Extension modes 1, 2, 3, each changed mid-cycle.
		wr(`TPU_ADDR_EXT, 32'h10);
		ext_on = 1;
		ext_new = 1;
		setup(8'hf8, 8'hfc, 8'hf1);
		for (int e = 2; e < 5; e++) begin
			run(10, 2'b11);
			wr(`TPU_ADDR_EXT, 32'((e % 4) << 4));
			ext_new = e % 4;
			run(22, 2'b11);
		end
		// Event counting: slow ticks ignored, pin edges counted.
		wr(`TPU_ADDR_CFG, 32'h2);
		setup(8'h10, 8'h00, 8'h80);
		tk(3);
		rdc(`TPU_ADDR_COUNT, 32'h10, "no slow count");
		repeat (5) begin
			@(posedge clk);
			evt <= 1'b1;
			repeat (2) @(posedge clk);
			evt <= 1'b0;
			repeat (2) @(posedge clk);
		end
		rdc(`TPU_ADDR_COUNT, 32'h15, "event count");
		stop_test();
	end
endmodule : testbench
